// ===== logic/error_class_flags.sv
// error class flags, indicators, reactions and field-bus status word
// assumes err_rpt, cold_start, prog_start and remote_count come from
// logic on sys_clk; site pins are asynchronous and are synchronised here
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps

module error_class_flags
  import err_flags_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire err_flags_pkg::avmm_req_t avm_req,
  output err_flags_pkg::avmm_rsp_t avm_rsp,
  input wire err_flags_pkg::err_report_t err_rpt,
  input wire err_flags_pkg::site_in_t site_pins,
  input wire logic cold_start,
  input wire logic prog_start,
  input wire logic [err_flags_pkg::CNT_W-1:0] remote_count,
  output err_flags_pkg::indicator_t ind,
  output err_flags_pkg::reaction_t react,
  output logic [15:0] remote_bus_status_word,
  output logic irq
);
  import err_flags_pkg::*;

  typedef struct packed {
    logic [NUM_CLS-1:0] cls;
    logic [2:0] lind;
    logic [NUM_CLS-1:0] irq_sts;
    logic [NUM_CLS-1:0] irq_mask;
    logic abort_sel;
    logic [CNT_W-1:0] max_cnt;
    logic [15:0] bus_sts;
    bus_state_t bst;
    logic [DATA_W-1:0] rdata;
    logic run_prev;
    logic pf_prev;
  } st_t;
  st_t s_q, s_d;

  site_in_t site;
  logic [WORD_W-1:0] rec_rd;
  logic run_rise;
  logic pf_rise;
  logic rec_clear;
  logic acc_wr;
  logic sw_rec_we;
  logic [DATA_W-1:0] flags_word;
  logic [NUM_CLS-1:0] cls_clr;
  logic [NUM_CLS-1:0] w1c;
  logic ack_clr;

  // pins from the panel and board are asynchronous
  pin_sync #(
    .W($bits(site_in_t))
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(site_pins),
    .level(site)
  );

  // edge events on the synchronised pins
  assign run_rise = site.run_switch & ~s_q.run_prev;
  assign pf_rise = site.power_fail & ~s_q.pf_prev;

  // without a battery the record ram does not survive a power fail
  assign rec_clear = cold_start | (pf_rise & ~site.battery);

  // a write takes effect only at the edge where waitrequest is low
  assign acc_wr = avm_req.write & (s_q.bst == BUS_ACK);
  assign sw_rec_we = acc_wr & avm_req.address[REC_SEL_BIT];

  // identifier and detail words live in the record store
  record_store u_rec (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(rec_clear),
    .hw_we(err_rpt.rec_we),
    .hw_idx({err_rpt.rec_cls, err_rpt.rec_word}),
    .hw_data(err_rpt.rec_data),
    .sw_we(sw_rec_we),
    .sw_idx(avm_req.address[REC_IDX_W-1:0]),
    .sw_data(avm_req.writedata[WORD_W-1:0]),
    .rd_idx(avm_req.address[REC_IDX_W-1:0]),
    .rd_data(rec_rd)
  );

  // flag word image: sum bit plus one bit per class
  always_comb begin
    flags_word = '0;
    flags_word[FLAG_SUM_BIT] = |s_q.cls;
    flags_word[FLAG_CLS_LSB +: NUM_CLS] = s_q.cls;
  end

  // acknowledge sources for light and warning classes
  assign ack_clr = cold_start | run_rise | prog_start;

  // clear terms per class; fatal and serious only by cold start or reset
  always_comb begin
    cls_clr = '0;
    cls_clr[CLS_FATAL] = cold_start;
    cls_clr[CLS_SERIOUS] = cold_start;
    cls_clr[CLS_LIGHT] = ack_clr;
    cls_clr[CLS_WARN] = ack_clr;
    if (acc_wr && avm_req.address == REG_FLAGS) begin
      // software acknowledges by writing the flag false
      if (!avm_req.writedata[FLAG_CLS_LSB + CLS_LIGHT]) cls_clr[CLS_LIGHT] = 1'b1;
      if (!avm_req.writedata[FLAG_CLS_LSB + CLS_WARN]) cls_clr[CLS_WARN] = 1'b1;
    end
  end

  // interrupt status bits are cleared by writing one
  assign w1c = (acc_wr && avm_req.address == REG_IRQ_STS) ?
               avm_req.writedata[NUM_CLS-1:0] : '0;

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.run_prev = site.run_switch;
    s_d.pf_prev = site.power_fail;
    // flags stay latched; a new event in the clearing cycle wins
    s_d.cls = (s_q.cls & ~cls_clr) | err_rpt.cls_evt;
    // light sub-indicators follow the light flag's acknowledgement
    if (cls_clr[CLS_LIGHT]) s_d.lind = '0;
    if (err_rpt.cls_evt[CLS_LIGHT]) begin
      unique case (err_rpt.ltype)
        LT_NONE: s_d.lind = s_d.lind;
        LT_BUS: s_d.lind[2] = 1'b1;
        LT_REMOTE: s_d.lind[1] = 1'b1;
        LT_SERIAL: s_d.lind[0] = 1'b1;
      endcase
    end
    s_d.irq_sts = (s_q.irq_sts & ~w1c) | err_rpt.cls_evt;
    // highest module count, restarted by a cold start
    if (cold_start) s_d.max_cnt = '0;
    else if (remote_count > s_q.max_cnt) s_d.max_cnt = remote_count;
    // status word rebuilt every cycle from current state
    s_d.bus_sts = '0;
    s_d.bus_sts[ST_NO_SERIOUS] = ~s_q.cls[CLS_SERIOUS];
    s_d.bus_sts[ST_IN_CYCLE] = site.slave_role & site.in_bus_cycle;
    s_d.bus_sts[ST_TIME_OK] = site.time_valid;
    s_d.bus_sts[ST_BATTERY] = site.battery;
    s_d.bus_sts[ST_CNT_LSB +: CNT_W] = s_q.max_cnt;
    // register writes
    if (acc_wr) begin
      unique case (avm_req.address)
        REG_IRQ_MASK: s_d.irq_mask = avm_req.writedata[NUM_CLS-1:0];
        REG_CTRL: s_d.abort_sel = avm_req.writedata[CTRL_ABORT_BIT];
        default: s_d.irq_mask = s_d.irq_mask;
      endcase
    end
    // one wait cycle per access, read data caught on the way into ack
    unique case (s_q.bst)
      BUS_IDLE: begin
        if (avm_req.read || avm_req.write) s_d.bst = BUS_ACK;
        s_d.rdata = '0;
        if (avm_req.read) begin
          if (avm_req.address[REC_SEL_BIT]) s_d.rdata = {16'h0000, rec_rd};
          else begin
            unique case (avm_req.address)
              REG_FLAGS: s_d.rdata = flags_word;
              REG_IRQ_STS: s_d.rdata = {28'h0000000, s_q.irq_sts};
              REG_IRQ_MASK: s_d.rdata = {28'h0000000, s_q.irq_mask};
              REG_CTRL: s_d.rdata = {31'h00000000, s_q.abort_sel};
              REG_BUS_STS: s_d.rdata = {16'h0000, s_q.bus_sts};
              default: s_d.rdata = '0;
            endcase
          end
        end
      end
      BUS_ACK: s_d.bst = BUS_IDLE;
    endcase
  end

  // power-on clears every flag and indicator
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.abort_sel <= CTRL_ABORT_RST;
      s_q.bst <= BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // avalon answer: combinational handshake, registered data
  assign avm_rsp.waitrequest = (avm_req.read | avm_req.write) & (s_q.bst != BUS_ACK);
  assign avm_rsp.readdata = s_q.rdata;

  // panel indicators straight from the latched flags
  assign ind.fatal = s_q.cls[CLS_FATAL];
  assign ind.serious = s_q.cls[CLS_SERIOUS];
  assign ind.light = s_q.cls[CLS_LIGHT];
  assign ind.bus_err = s_q.lind[2];
  assign ind.remote_err = s_q.lind[1];
  assign ind.serial_err = s_q.lind[0];

  // reactions; the programming port never loses access
  assign react.outputs_false = s_q.cls[CLS_FATAL] | s_q.cls[CLS_SERIOUS];
  assign react.prog_port_ok = 1'b1;
  assign react.prog_run_ok = ~(s_q.cls[CLS_FATAL] | s_q.cls[CLS_SERIOUS] |
                               (s_q.cls[CLS_LIGHT] & s_q.abort_sel));

  assign remote_bus_status_word = s_q.bus_sts;
  assign irq = |(s_q.irq_sts & s_q.irq_mask);

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // any class event must show up in the sum bit one cycle later
  property p_sum_or;
    (|err_rpt.cls_evt) |=> flags_word[FLAG_SUM_BIT];
  endproperty
  a_sum_or: assert property (p_sum_or) else $error("sum flag not or of classes");

  property p_fatal_held;
    s_q.cls[CLS_FATAL] && !cold_start |=> s_q.cls[CLS_FATAL];
  endproperty
  a_fatal_held: assert property (p_fatal_held) else $error("fatal flag lost");

  property p_light_run_clr;
    run_rise && !err_rpt.cls_evt[CLS_LIGHT] |=> !s_q.cls[CLS_LIGHT];
  endproperty
  a_light_run_clr: assert property (p_light_run_clr) else $error("light not cleared");

  property p_reset_again;
    err_rpt.cls_evt[CLS_SERIOUS] |=> s_q.cls[CLS_SERIOUS] && ind.serious;
  endproperty
  a_reset_again: assert property (p_reset_again) else $error("serious not set");

  property p_out_false;
    s_q.cls[CLS_FATAL] || s_q.cls[CLS_SERIOUS] |->
      react.outputs_false && !react.prog_run_ok && react.prog_port_ok;
  endproperty
  a_out_false: assert property (p_out_false) else $error("outputs not forced");

  property p_light_report;
    s_q.cls[CLS_LIGHT] && !react.outputs_false |->
      react.prog_run_ok == !s_q.abort_sel;
  endproperty
  a_light_report: assert property (p_light_report) else $error("light reaction wrong");

  property p_bit0;
    nrst |=> remote_bus_status_word[ST_NO_SERIOUS] == !$past(s_q.cls[CLS_SERIOUS]);
  endproperty
  a_bit0: assert property (p_bit0) else $error("status bit 0 wrong");

  property p_bit1;
    nrst |=> remote_bus_status_word[ST_IN_CYCLE] ==
      $past(site.slave_role && site.in_bus_cycle);
  endproperty
  a_bit1: assert property (p_bit1) else $error("status bit 1 wrong");

  property p_max_grow;
    !cold_start |=> s_q.max_cnt >= $past(s_q.max_cnt);
  endproperty
  a_max_grow: assert property (p_max_grow) else $error("max count fell");

  property p_unused_bits;
    remote_bus_status_word[7:4] == 4'h0;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("bits 4..7 set");

  property p_light_led;
    err_rpt.cls_evt[CLS_LIGHT] && err_rpt.ltype == LT_REMOTE |=> ind.light && ind.remote_err;
  endproperty
  a_light_led: assert property (p_light_led) else $error("light leds off");

  property p_ack_once;
    (avm_req.read || avm_req.write) && avm_rsp.waitrequest |=> !avm_rsp.waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("access not answered");

  // light flag stays up unless one of its acknowledgement events is present
  property p_light_sticky;
    s_q.cls[CLS_LIGHT] && !cls_clr[CLS_LIGHT] |=> s_q.cls[CLS_LIGHT];
  endproperty
  a_light_sticky: assert property (p_light_sticky) else $error("light flag lost");

  property p_fatal_cold;
    cold_start && !err_rpt.cls_evt[CLS_FATAL] |=> !s_q.cls[CLS_FATAL];
  endproperty
  a_fatal_cold: assert property (p_fatal_cold) else $error("fatal not cleared");

  property p_sw_clr;
    acc_wr && avm_req.address == REG_FLAGS &&
      !avm_req.writedata[FLAG_CLS_LSB + CLS_LIGHT] && !err_rpt.cls_evt[CLS_LIGHT] |=>
      !s_q.cls[CLS_LIGHT];
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("light not cleared by write");

  // sub-indicators go dark with the light flag's acknowledgement
  property p_lind_clear;
    cls_clr[CLS_LIGHT] && !err_rpt.cls_evt[CLS_LIGHT] |=>
      !(ind.bus_err || ind.remote_err || ind.serial_err);
  endproperty
  a_lind_clear: assert property (p_lind_clear) else $error("light leds stuck");

  // the remaining status fields follow their sources with one cycle of lag
  property p_bit2;
    nrst |=> remote_bus_status_word[ST_TIME_OK] == $past(site.time_valid);
  endproperty
  a_bit2: assert property (p_bit2) else $error("status bit 2 wrong");

  property p_bit3;
    nrst |=> remote_bus_status_word[ST_BATTERY] == $past(site.battery);
  endproperty
  a_bit3: assert property (p_bit3) else $error("status bit 3 wrong");

  property p_cnt_field;
    nrst |=> remote_bus_status_word[ST_CNT_LSB +: CNT_W] == $past(s_q.max_cnt);
  endproperty
  a_cnt_field: assert property (p_cnt_field) else $error("count field wrong");

  property p_cold_cnt;
    cold_start |=> s_q.max_cnt == '0;
  endproperty
  a_cold_cnt: assert property (p_cold_cnt) else $error("count not restarted");

  // a mask write in the same cycle may legally hide the new event
  property p_irq_set;
    err_rpt.cls_evt[CLS_LIGHT] && s_q.irq_mask[CLS_LIGHT] &&
      !(acc_wr && avm_req.address == REG_IRQ_MASK) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

  c_fatal_set: cover property (err_rpt.cls_evt[CLS_FATAL] ##1 react.outputs_false);
  c_light_ack: cover property (s_q.cls[CLS_LIGHT] ##1 !s_q.cls[CLS_LIGHT]);
  c_bus_read: cover property (avm_req.read && !avm_rsp.waitrequest);
  c_irq: cover property (irq);
  c_run_ack: cover property (run_rise ##1 !s_q.cls[CLS_LIGHT]);
endmodule : error_class_flags

// ===== pkg/err_flags_pkg.sv
// constants, types and register map of the error-class flag block
// assumes a word-addressed avalon-mm slave port and one 40 mhz clock
package err_flags_pkg;
  // register word indices on the avalon-mm port
  localparam int ADDR_W = 6;
  localparam logic [5:0] REG_FLAGS = 6'h00;
  localparam logic [5:0] REG_IRQ_STS = 6'h01;
  localparam logic [5:0] REG_IRQ_MASK = 6'h02;
  localparam logic [5:0] REG_CTRL = 6'h03;
  localparam logic [5:0] REG_BUS_STS = 6'h04;
  localparam int REC_SEL_BIT = 5;
  localparam int REC_IDX_W = 5;

  // error classes, also the bit order of every per-class field
  localparam int NUM_CLS = 4;
  localparam int CLS_FATAL = 0;
  localparam int CLS_SERIOUS = 1;
  localparam int CLS_LIGHT = 2;
  localparam int CLS_WARN = 3;

  // flag word layout
  localparam int FLAG_SUM_BIT = 10;
  localparam int FLAG_CLS_LSB = 11;

  // control register layout and reset value
  localparam int CTRL_ABORT_BIT = 0;
  localparam logic CTRL_ABORT_RST = 1'h0;

  // field-bus status word layout
  localparam int ST_NO_SERIOUS = 0;
  localparam int ST_IN_CYCLE = 1;
  localparam int ST_TIME_OK = 2;
  localparam int ST_BATTERY = 3;
  localparam int ST_CNT_LSB = 8;
  localparam int CNT_W = 8;

  // error record store: eight 16-bit words per class
  localparam int REC_WORDS = 8;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;

  typedef enum logic [1:0] {
    LT_NONE = 2'h0,
    LT_BUS = 2'h1,
    LT_REMOTE = 2'h3,
    LT_SERIAL = 2'h2
  } light_type_t;

  typedef enum logic {
    BUS_IDLE = 1'h0,
    BUS_ACK = 1'h1
  } bus_state_t;

  typedef struct packed {
    logic [NUM_CLS-1:0] cls_evt;
    light_type_t ltype;
    logic rec_we;
    logic [1:0] rec_cls;
    logic [2:0] rec_word;
    logic [WORD_W-1:0] rec_data;
  } err_report_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef struct packed {
    logic run_switch;
    logic power_fail;
    logic battery;
    logic time_valid;
    logic slave_role;
    logic in_bus_cycle;
  } site_in_t;

  typedef struct packed {
    logic fatal;
    logic serious;
    logic light;
    logic bus_err;
    logic remote_err;
    logic serial_err;
  } indicator_t;

  typedef struct packed {
    logic outputs_false;
    logic prog_port_ok;
    logic prog_run_ok;
  } reaction_t;
endpackage : err_flags_pkg

// ===== logic/pin_sync.sv
// three-stage synchroniser with agreement filter for slow pins
// assumes inputs change far slower than sys_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 6
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } st_t;
  st_t s_q, s_d;

  // a bit only moves once stages two and three agree; stage one feeds stage two only
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) s_d.o[i] = s_q.s3[i];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end

  assign level = s_q.o;
endmodule : pin_sync

// ===== logic/record_store.sv
// error identifier and detail words, eight per class
// assumes one hardware writer and one software writer on the same clock
`timescale 1ns/1ps
module record_store
  import err_flags_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic hw_we,
  input wire logic [REC_IDX_W-1:0] hw_idx,
  input wire logic [WORD_W-1:0] hw_data,
  input wire logic sw_we,
  input wire logic [REC_IDX_W-1:0] sw_idx,
  input wire logic [WORD_W-1:0] sw_data,
  input wire logic [REC_IDX_W-1:0] rd_idx,
  output logic [WORD_W-1:0] rd_data
);
  localparam int ENTRIES = NUM_CLS * REC_WORDS;
  logic [ENTRIES-1:0][WORD_W-1:0] mem_q, mem_d;

  // a hardware report beats both a software write and a clear in the same cycle,
  // so an error raised during a cold start still leaves its record behind
  always_comb begin
    mem_d = mem_q;
    if (sw_we) mem_d[sw_idx] = sw_data;
    if (clear) mem_d = '0;
    if (hw_we) mem_d[hw_idx] = hw_data;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) mem_q <= '0;
    else mem_q <= mem_d;
  end

  assign rd_data = mem_q[rd_idx];
endmodule : record_store

// ===== bench/error_class_flags_tb_top.sv
// bench for the error class flag block: a table of class events, then hand-written cases
// assumes the design package, a word-addressed avalon-mm port and a 40 mhz sys_clk
`timescale 1ns/1ps
module error_class_flags_tb_top;
  import err_flags_pkg::*;
  typedef struct packed {
    logic [3:0] evt;
    light_type_t lt;
    logic abort;
    logic [5:0] ind_m;
    logic [5:0] ind_e;
    logic [15:0] flg;
    logic [2:0] rct;
  } row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  avmm_req_t req = '0;
  avmm_rsp_t rsp;
  err_report_t rpt = '0;
  site_in_t pins = '0;
  logic cold = 1'b0;
  logic pstart = 1'b0;
  logic [7:0] rcnt = 8'h00;
  indicator_t ind;
  reaction_t react;
  logic [15:0] bsw;
  logic irq;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] q;
  // one row per class event; a warning lights no class indicator at all
  row_t rows [8] = '{
    {4'h1, LT_NONE, 1'b0, 6'h3f, 6'h20, 16'h0c00, 3'h6},
    {4'h2, LT_NONE, 1'b0, 6'h3f, 6'h10, 16'h1400, 3'h6},
    {4'h4, LT_BUS, 1'b0, 6'h3f, 6'h0c, 16'h2400, 3'h3},
    {4'h4, LT_REMOTE, 1'b0, 6'h3f, 6'h0a, 16'h2400, 3'h3},
    {4'h4, LT_SERIAL, 1'b0, 6'h3f, 6'h09, 16'h2400, 3'h3},
    {4'h4, LT_REMOTE, 1'b1, 6'h3f, 6'h0a, 16'h2400, 3'h2},
    {4'h4, LT_NONE, 1'b0, 6'h3f, 6'h08, 16'h2400, 3'h3},
    {4'h8, LT_NONE, 1'b0, 6'h3f, 6'h00, 16'h4400, 3'h3}
  };

  // 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  error_class_flags DUT (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .avm_req(req),
    .avm_rsp(rsp),
    .err_rpt(rpt),
    .site_pins(pins),
    .cold_start(cold),
    .prog_start(pstart),
    .remote_count(rcnt),
    .ind(ind),
    .react(react),
    .remote_bus_status_word(bsw),
    .irq(irq)
  );

  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // one access, entered just after a rising edge; the request stands until the edge
  // at which waitrequest is sampled low, and read data is taken at that same edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    if (rsp.waitrequest !== 1'b0) begin
      chk("waitrequest", 32'h0, 32'h1);
      give_verdict();
    end
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    // a free edge so a following request never lands in the release time step
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd

  task automatic evt(input logic [3:0] c, input light_type_t t);
    rpt.cls_evt <= c;
    rpt.ltype <= t;
    tick(1);
    rpt.cls_evt <= 4'h0;
    rpt.ltype <= LT_NONE;
    tick(3);
  endtask : evt

  // one-cycle cold start and/or program start pulse
  task automatic ack(input logic c, input logic p);
    cold <= c;
    pstart <= p;
    tick(1);
    cold <= 1'b0;
    pstart <= 1'b0;
    tick(2);
  endtask : ack

  task automatic rec(input logic [1:0] c, input logic [2:0] w, input logic [15:0] d);
    rpt.rec_we <= 1'b1;
    rpt.rec_cls <= c;
    rpt.rec_word <= w;
    rpt.rec_data <= d;
    tick(1);
    rpt.rec_we <= 1'b0;
    tick(1);
  endtask : rec

  initial begin
    tick(2);
    nrst <= 1'b1;
    tick(6);
    chk("ind", 32'h0, {26'h0, ind});
    chk("react", 32'h3, {29'h0, react});
    rd("flags", REG_FLAGS, 32'h0);
    rd("mask", REG_IRQ_MASK, 32'h0);
    rd("ctrl", REG_CTRL, 32'h0);
    rd("bus_sts", REG_BUS_STS, 32'h1);
    wr(REG_IRQ_MASK, 32'hf);
    // table: each class event, held for a while, then cleared by cold start
    foreach (rows[i]) begin
      wr(REG_CTRL, {31'h0, rows[i].abort});
      evt(rows[i].evt, rows[i].lt);
      tick(4);
      chk("ind", {26'h0, rows[i].ind_e}, {26'h0, ind & rows[i].ind_m});
      chk("react", {29'h0, rows[i].rct}, {29'h0, react});
      chk("irq", 32'h1, {31'h0, irq});
      rd("flags", REG_FLAGS, {16'h0, rows[i].flg});
      rd("irq_sts", REG_IRQ_STS, {28'h0, rows[i].evt});
      rd("bus_sts", REG_BUS_STS, {31'h0, !rows[i].evt[CLS_SERIOUS]});
      chk("bus_word", {31'h0, !rows[i].evt[CLS_SERIOUS]}, {16'h0, bsw});
      wr(REG_IRQ_STS, {28'h0, rows[i].evt});
      chk("irq_clr", 32'h0, {31'h0, irq});
      ack(1'b1, 1'b0);
      rd("flags_cold", REG_FLAGS, 32'h0);
    end
    wr(REG_CTRL, 32'h0);
    // light and warning: writing ones does nothing, a zero write, program start and run switch each clear
    for (int m = 0; m < 3; m++) begin
      evt(4'hc, LT_BUS);
      wr(REG_FLAGS, 32'h6000);
      rd("flags_w1", REG_FLAGS, 32'h6400);
      case (m)
        0: wr(REG_FLAGS, 32'h0);
        1: ack(1'b0, 1'b1);
        default: begin
          pins.run_switch <= 1'b1;
          tick(8);
          pins.run_switch <= 1'b0;
        end
      endcase
      tick(2);
      rd("flags_ack", REG_FLAGS, 32'h0);
      chk("ind_ack", 32'h0, {26'h0, ind});
    end
    // fatal and serious survive a zero write and a program start but not a cold start, and serious comes back if raised again
    evt(4'h3, LT_NONE);
    wr(REG_FLAGS, 32'h0);
    ack(1'b0, 1'b1);
    rd("flags_fs", REG_FLAGS, 32'h1c00);
    ack(1'b1, 1'b0);
    evt(4'h2, LT_NONE);
    rd("flags_again", REG_FLAGS, 32'h1400);
    ack(1'b1, 1'b0);
    // records: hardware fill, untouched by acknowledgement, software overwrite, clears
    for (int c = 0; c < 4; c++) begin
      rec(2'(c), 3'(c), 16'h1230 + 16'(c));
    end
    ack(1'b0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      rd("record", 6'h20 + 6'(9 * c), 32'h1230 + 32'(c));
    end
    wr(6'h20, 32'hffff_beef);
    rd("record_sw", 6'h20, 32'h0000_beef);
    ack(1'b1, 1'b0);
    rd("record_cold", 6'h20, 32'h0);
    rd("record_cold", 6'h32, 32'h0);
    rec(2'h3, 3'h0, 16'h0042);
    pins.battery <= 1'b1;
    tick(8);
    pins.power_fail <= 1'b1;
    tick(8);
    rd("record_batt", 6'h38, 32'h42);
    pins.power_fail <= 1'b0;
    pins.battery <= 1'b0;
    tick(8);
    pins.power_fail <= 1'b1;
    tick(8);
    rd("record_pfail", 6'h38, 32'h0);
    pins.power_fail <= 1'b0;
    // status word: role, time, battery and the peak remote count since cold start
    pins.slave_role <= 1'b1;
    pins.in_bus_cycle <= 1'b1;
    pins.time_valid <= 1'b1;
    pins.battery <= 1'b1;
    rcnt <= 8'h05;
    tick(2);
    rcnt <= 8'h03;
    tick(8);
    rd("bus_sts", REG_BUS_STS, 32'h050f);
    pins.slave_role <= 1'b0;
    wr(REG_BUS_STS, 32'h0);
    ack(1'b1, 1'b0);
    tick(6);
    rd("bus_sts", REG_BUS_STS, 32'h030d);
    chk("bus_word", 32'h030d, {16'h0, bsw});
    // interrupt masking and an unmapped word
    wr(REG_IRQ_STS, 32'hf);
    wr(REG_IRQ_MASK, 32'h8);
    evt(4'h4, LT_SERIAL);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_MASK, 32'h4);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(6'h10, 32'hffff_ffff);
    rd("unmapped", 6'h10, 32'h0);
    // reset in mid-run with flags raised clears them, the peak count tracks afresh
    evt(4'h3, LT_NONE);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(6);
    chk("ind_rst", 32'h0, {26'h0, ind});
    rd("flags_rst", REG_FLAGS, 32'h0);
    rd("bus_sts_rst", REG_BUS_STS, 32'h030d);
    give_verdict();
  end
endmodule : error_class_flags_tb_top
